/* core/t16cs_pkg.sv */
// Package for the 16-bit timer control and clock select block.
// Assumes a single 40 MHz system clock and a plain register port.
package t16cs_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_COUNT_LO = 2'h1;
  localparam logic [1:0] ADDR_COUNT_HI = 2'h2;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // ****************************************************************
  // Field positions of the control register
  // ****************************************************************
  localparam int CS_LSB     = 6;
  localparam int CKPS_LSB   = 4;
  localparam int SECONDARY_OSC_ENABLE_BIT  = 3;
  localparam int SYNC_BIT   = 2;
  localparam int UNUSED_BIT = 1;
  localparam int ON_BIT     = 0;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [1:0] CS_INSTR   = 2'h0;
  localparam logic [1:0] CS_SYSTEM  = 2'h1;
  localparam logic [1:0] CS_PIN_OSC = 2'h2;
  localparam logic [1:0] CS_RESERVD = 2'h3;

  // Instruction clock is the system clock divided by four.
  localparam int INSTR_DIV = 4;

endpackage : t16cs_pkg

/* core/t16cs_prescaler.sv */
// Prescaler for the timer input clock: divides a tick stream by 1, 2, 4 or 8.
// Assumes ticks are one-cycle enables on the system clock.
`timescale 1ns/1ps

module t16cs_prescaler
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic [1:0] sel,
  input  wire logic       tick_in,
  output logic            tick_out
);

  logic [2:0] cnt_q;
  logic [2:0] mask;

  always_comb
  begin
    mask = 3'h0;
    unique case (sel)
      2'h0: mask = 3'h0;
      2'h1: mask = 3'h1;
      2'h2: mask = 3'h3;
      2'h3: mask = 3'h7;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || clear)
      cnt_q <= 3'h0;
    else if (tick_in)
      cnt_q <= (cnt_q & mask) == mask ? 3'h0 : cnt_q + 3'h1;
  end

  assign tick_out = tick_in && ((cnt_q & mask) == mask);

endmodule // t16cs_prescaler

/* core/t16cs_top.sv */
// Control register, clock select, prescaler and 16-bit counter of a timer.
// Assumes all pin inputs are synchronous to clk; rst_n is power-on reset.
`timescale 1ns/1ps

module t16cs_top
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  input  wire logic        ext_clock_pin,
  input  wire logic        crystal_clk,
  output logic             secondary_osc_enable,
  output logic             gate_toggle_clear,
  output logic             timer_running,
  output logic      [15:0] count
);
  import t16cs_pkg::*;

  // ****************************************************************
  // Control register
  // ****************************************************************
  logic [7:0] control_q;
  logic [1:0] clk_src;
  logic [1:0] prescale_select;
  logic       osc_en;
  logic       sync_bypass;
  logic       timer_on;
  logic       wr_control;
  logic       wr_count_lo;
  logic       wr_count_hi;

  // Address decode of the write strobe, one select per register.
  assign wr_control  = wr && (addr == ADDR_CONTROL);
  assign wr_count_lo = wr && (addr == ADDR_COUNT_LO);
  assign wr_count_hi = wr && (addr == ADDR_COUNT_HI);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      control_q <= CONTROL_RESET;
    else if (wr_control)
      control_q <= wdata & ~(8'h01 << UNUSED_BIT);
  end

  assign clk_src         = control_q[CS_LSB +: 2];
  assign prescale_select = control_q[CKPS_LSB +: 2];
  assign osc_en          = control_q[SECONDARY_OSC_ENABLE_BIT];
  assign sync_bypass     = control_q[SYNC_BIT];
  assign timer_on        = control_q[ON_BIT];

  // ****************************************************************
  // Control outputs
  // ****************************************************************
  // Each output is its own flop, one control cycle behind the register.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      secondary_osc_enable <= 1'b0;
    else
      secondary_osc_enable <= osc_en;
  end

  // The gate toggle flop is held clear for as long as the timer is off.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      gate_toggle_clear <= 1'b1;
    else
      gate_toggle_clear <= !timer_on;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      timer_running <= 1'b0;
    else
      timer_running <= timer_on;
  end

  // ****************************************************************
  // Instruction clock divider
  // ****************************************************************
  logic [1:0] instr_div_q;
  logic       instr_tick;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      instr_div_q <= 2'h0;
    else
      instr_div_q <= instr_div_q + 2'h1;
  end

  assign instr_tick = instr_div_q == 2'(INSTR_DIV - 1);

  // ****************************************************************
  // External source edge detection
  // ****************************************************************
  // The pin and crystal are sampled; a rising edge becomes one tick.
  // With sync on, two extra sampling stages align the edge to clk.
  logic ext_src;
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_prev_q;
  logic ext_level;
  logic ext_tick;

  assign ext_src = osc_en ? crystal_clk : ext_clock_pin;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ext_s1_q   <= 1'b0;
      ext_s2_q   <= 1'b0;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      ext_s1_q   <= ext_src;
      ext_s2_q   <= ext_s1_q;
      ext_prev_q <= ext_level;
    end
  end

  assign ext_level = sync_bypass ? ext_src : ext_s2_q;
  assign ext_tick  = ext_level && !ext_prev_q;

  // ****************************************************************
  // Clock source select
  // ****************************************************************
  logic src_tick;

  always_comb
  begin
    src_tick = 1'b0;
    unique case (clk_src)
      CS_INSTR:   src_tick = instr_tick;
      CS_SYSTEM:  src_tick = 1'b1;
      CS_PIN_OSC: src_tick = ext_tick;
      CS_RESERVD: src_tick = 1'b0;
    endcase
  end

  // ****************************************************************
  // Prescaler and counter
  // ****************************************************************
  logic pre_tick;

  t16cs_prescaler u_prescaler
  (
    .clk      (clk),
    .rst_n    (rst_n),
    .clear    (!timer_on),
    .sel      (prescale_select),
    .tick_in  (src_tick && timer_on),
    .tick_out (pre_tick)
  );

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      count <= 16'h0000;
    // A software write wins over an increment in the same cycle.
    else if (wr_count_lo)
      count[7:0] <= wdata;
    else if (wr_count_hi)
      count[15:8] <= wdata;
    else if (timer_on && pre_tick)
      count <= count + 16'h0001;
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (rd)
    begin
      unique case (addr)
        ADDR_CONTROL:  rdata <= control_q;
        ADDR_COUNT_LO: rdata <= count[7:0];
        ADDR_COUNT_HI: rdata <= count[15:8];
        default:       rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

endmodule // t16cs_top

/* tb/t16cs_chk.sv */
// Checker of the timer control block.
// Sees only the top ports; bound from tb.
`timescale 1ns/1ps
module t16cs_chk
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [1:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic        secondary_osc_enable,
  input wire logic        gate_toggle_clear,
  input wire logic        timer_running,
  input wire logic [15:0] count,
  input wire logic        ext_clock_pin
);
  logic [7:0] ctl_q;
  always_ff @(posedge clk)
    if (!rst_n) ctl_q <= 8'h00;
    else if (wr && addr == 2'h0) ctl_q <= wdata & 8'hfd;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence ctl_wr; wr && addr == 2'h0; endsequence
  osc_follow_a: assert property (ctl_wr |=> ##1 secondary_osc_enable == $past(wdata[3], 2))
    else $error("osc enable");
  on_follow_a: assert property (ctl_wr |=> ##1 timer_running == $past(wdata[0], 2))
    else $error("on bit");
  gate_clear_a: assert property (gate_toggle_clear == !timer_running)
    else $error("gate clear");
  ctl_read_a: assert property (rd && addr == 2'h0 |=> rdata == ctl_q)
    else $error("control read");
  reset_clear_a: assert property ($rose(rst_n) |-> count == 16'h0000 && gate_toggle_clear)
    else $error("reset");
  sys_rate_a: assert property (ctl_q == 8'h41 && !wr |=> count == $past(count) + 16'h1)
    else $error("system rate");
  off_hold_a: assert property (!ctl_q[0] && !$past(ctl_q[0]) && !wr |=> $stable(count))
    else $error("off hold");
  div_two_a: assert property (ctl_q == 8'h51 && $past(ctl_q) == 8'h51 && $changed(count)
    && !wr && !$past(wr) |=> $stable(count))
    else $error("divide by two");
  // Pin source, divide by one, on: bypass counts the edge at once, sync two clocks later.
  sequence pin_rise_bypass;
    $rose(ext_clock_pin) && ctl_q == 8'h85 && $past(ctl_q) == 8'h85 && !wr;
  endsequence
  sequence pin_rise_sync;
    ($rose(ext_clock_pin) && ctl_q == 8'h81) ##2 (ctl_q == 8'h81 && !wr);
  endsequence
  bypass_edge_a: assert property (pin_rise_bypass |=> count == $past(count) + 16'h1)
    else $error("bypass edge");
  sync_edge_a: assert property (pin_rise_sync |=> count == $past(count) + 16'h1)
    else $error("sync edge");
endmodule // t16cs_chk

/* tb/tb.sv */
// Testbench of the timer control block.
// Drives the register port and both count pins itself.
`timescale 1ns/1ps
module tb;
  import t16cs_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, pin = 0, xtal = 0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, rdata, v0, v1;
  logic osc, gclr, run;
  logic [15:0] count;
  int err_count = 0, tests_run = 0, ph = 0;
  // Control value in the high byte, expected counts per 32 clocks in the low byte.
  logic [15:0] tbl [12] = '{
    16'h4120, 16'h5110, 16'h6108, 16'h7104,
    16'h0108, 16'h1104, 16'h3101,
    16'h8108, 16'h8508, 16'h8904, 16'h8d04,
    16'h4000};
  t16cs_top DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ext_clock_pin(pin), .crystal_clk(xtal), .secondary_osc_enable(osc),
    .gate_toggle_clear(gclr), .timer_running(run), .count(count));
  initial forever #12.5 clk = ~clk;
  // The crystal only swings while its oscillator is enabled.
  always @(posedge clk)
  begin
    ph <= ph + 1;
    pin <= ph[1];
    if (osc) xtal <= ph[2];
  end
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(ADDR_CONTROL, v0);
    chk(v0, CONTROL_RESET);
    wr_reg(ADDR_CONTROL, 8'h7f);
    rd_reg(ADDR_CONTROL, v0);
    chk(v0, 8'h7d);
    chk({5'h00, osc, gclr, run}, 8'h05);
    rd_reg(2'h3, v0);
    chk(v0, 8'h00);
    for (int i = 0; i < 12; i++)
    begin
      wr_reg(ADDR_CONTROL, tbl[i][15:8]);
      repeat (8) @(posedge clk);
      rd_reg(ADDR_COUNT_LO, v0);
      repeat (30) @(posedge clk);
      rd_reg(ADDR_COUNT_LO, v1);
      chk(v1 - v0, tbl[i][7:0]);
    end
    chk({5'h00, osc, gclr, run}, 8'h02);
    wr_reg(ADDR_COUNT_LO, 8'h34);
    wr_reg(ADDR_COUNT_HI, 8'h12);
    rd_reg(ADDR_COUNT_LO, v0);
    rd_reg(ADDR_COUNT_HI, v1);
    chk(v0, 8'h34);
    chk(v1, 8'h12);
    wr_reg(ADDR_CONTROL, 8'h45);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(ADDR_CONTROL, v0);
    chk(v0, CONTROL_RESET);
    chk({5'h00, osc, gclr, run}, 8'h02);
    rd_reg(ADDR_COUNT_HI, v0);
    chk(v0, 8'h00);
    final_report;
  end
endmodule // tb
bind t16cs_top t16cs_chk chk_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .secondary_osc_enable(secondary_osc_enable),
  .gate_toggle_clear(gate_toggle_clear), .timer_running(timer_running), .count(count),
  .ext_clock_pin(ext_clock_pin));
